// ---- hw/alu_defines.vh ----
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ACC 8'h04
`define OFS_OPND 8'h08
`define OFS_MEM 8'h0c
`define OFS_COUNT 8'h10
`define OFS_STATUS 8'h14
`define OFS_CORR 8'h18

// Control word fields
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 4
`define CTRL_DST_LSB 5
`define CTRL_DST_MSB 6
`define CTRL_IMM_SEL 7
`define CTRL_IMM_LSB 8
`define CTRL_IMM_MSB 15

// Status word fields
`define ST_C 0
`define ST_V 1
`define ST_Z 2
`define ST_N 3
`define ST_T 4
`define ST_BUSY 8
`define ST_CYC_LSB 16

// Correction word fields: (a) (b) (c) (d)
`define CORR_A_LSB 0
`define CORR_B_LSB 8
`define CORR_C_LSB 16
`define CORR_D_LSB 24

// Reset values
`define RST_WORD 32'h00000000
`define RST_BYTE 8'h00
`define RST_FLAGS 5'h00

// Operand location
`define DST_ACC 2'h0
`define DST_REG 2'h1
`define DST_MEM 2'h2

// Operation codes
`define OP_AND_L 5'h00
`define OP_OR_L 5'h01
`define OP_XOR_L 5'h02
`define OP_NEGATE_BYTE 5'h03
`define OP_NEGATE_WORD 5'h04
`define OP_MAGNITUDE_BYTE 5'h05
`define OP_MAGNITUDE_WORD 5'h06
`define OP_MAGNITUDE_LONG 5'h07
`define OP_NORMALIZE_LONG 5'h08
`define OP_ROTATE_RIGHT 5'h09
`define OP_ROTATE_LEFT 5'h0a
`define OP_ARITH_RIGHT_BYTE 5'h0b
`define OP_LOGIC_RIGHT_BYTE 5'h0c
`define OP_LOGIC_LEFT_BYTE 5'h0d
`define OP_ARITH_RIGHT_WORD 5'h0e
`define OP_LOGIC_RIGHT_WORD 5'h0f
`define OP_LOGIC_LEFT_WORD 5'h10
`define OP_ARITH_RIGHT_WORD1 5'h11
`define OP_LOGIC_RIGHT_WORD1 5'h12
`define OP_LOGIC_LEFT_WORD1 5'h13
`define OP_ARITH_RIGHT_LONG 5'h14
`define OP_LOGIC_RIGHT_LONG 5'h15
`define OP_LOGIC_LEFT_LONG 5'h16

// Shift width and direction codes
`define W_BYTE 2'h0
`define W_WORD 2'h1
`define W_LONG 2'h2
`define SH_ARITH_RIGHT 2'h0
`define SH_LOGIC_RIGHT 2'h1
`define SH_LOGIC_LEFT 2'h2

// Cycle counts
`define CYC_LOGIC_REG 16'd5
`define CYC_LOGIC_MEM 16'd6
`define CYC_NEG 16'd2
`define CYC_NEG_MEM 16'd3
`define CYC_ABS_BW 16'd2
`define CYC_ABS_L 16'd4
`define CYC_NORMALIZE_LONG 16'd5
`define CYC_ROT 16'd2
`define CYC_ROT_MEM 16'd3
`define CYC_SHIFT_ZERO 16'd3
`define CYC_SHIFT_BW 16'd3
`define CYC_SHIFT_L 16'd4
`define CYC_SHIFT1 16'd2

`endif

// ---- hw/logic_shift_normalize_alu.v ----
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module logic_shift_normalize_alu (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg busy
);

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_RUN = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  function [31:0] width_mask(input [1:0] w);
    begin
      case (w)
        `W_BYTE: width_mask = 32'h000000ff;
        `W_WORD: width_mask = 32'h0000ffff;
        default: width_mask = 32'hffffffff;
      endcase
    end
  endfunction

  function [15:0] shift_cycles(input [7:0] n, input is_long);
    begin
      if (n == 8'h00) begin
        shift_cycles = `CYC_SHIFT_ZERO;
      end else begin
        shift_cycles = (is_long ? `CYC_SHIFT_L : `CYC_SHIFT_BW) + {8'h00, n};
      end
    end
  endfunction

  function [1:0] dir_of(input [4:0] o, input [4:0] base);
    reg [4:0] d;
    begin
      d = o - base;
      dir_of = d[1:0];
    end
  endfunction

  function [5:0] lead_zeros(input [31:0] v);
    integer i;
    reg found;
    begin
      lead_zeros = 6'd0;
      found = 1'b0;
      for (i = 31; i >= 0; i = i - 1) begin
        if (!found) begin
          if (v[i]) begin
            found = 1'b1;
          end else begin
            lead_zeros = lead_zeros + 6'd1;
          end
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0] state_q;
  reg [15:0] remain_q;
  reg [31:0] acc_q;
  reg [31:0] opnd_q;
  reg [31:0] mem_q;
  reg [7:0] count_q;
  reg [4:0] flags_q;
  reg [15:0] ctrl_q;
  reg [31:0] corr_q;
  reg [15:0] last_cyc_q;
  reg [31:0] pend_val_q;
  reg [1:0] pend_dst_q;
  reg [4:0] pend_flags_q;
  reg [7:0] pend_count_q;
  reg pend_count_we_q;
  reg ap_wr_q;
  reg [7:0] ap_addr_q;

  wire ap_valid = hsel & htrans[1] & hready;
  wire idle = state_q[0];
  wire wr_ok = ap_wr_q & idle;
  wire [4:0] op = hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
  wire [1:0] dst = hwdata[`CTRL_DST_MSB:`CTRL_DST_LSB];
  wire [7:0] imm = hwdata[`CTRL_IMM_MSB:`CTRL_IMM_LSB];
  wire imm_sel = hwdata[`CTRL_IMM_SEL];
  wire [15:0] corr_a = {8'h00, corr_q[`CORR_A_LSB+7:`CORR_A_LSB]};
  wire [15:0] corr_b2 = {7'h00, corr_q[`CORR_B_LSB+7:`CORR_B_LSB], 1'b0};
  wire [15:0] corr_c2 = {7'h00, corr_q[`CORR_C_LSB+7:`CORR_C_LSB], 1'b0};
  wire [15:0] corr_d = {8'h00, corr_q[`CORR_D_LSB+7:`CORR_D_LSB]};
  wire [31:0] src = (dst == `DST_MEM) ? mem_q : ((dst == `DST_REG) ? opnd_q : acc_q);

  reg [1:0] sh_width;
  reg [1:0] sh_mode;
  reg [7:0] sh_amount;
  wire [31:0] sh_res;
  wire sh_carry;
  wire sh_sticky;

  shift_unit shifter (
    .val(acc_q),
    .width(sh_width),
    .mode(sh_mode),
    .amount(sh_amount),
    .res(sh_res),
    .carry(sh_carry),
    .sticky(sh_sticky)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result of the operation written to the control word, computed at start
  reg [31:0] e_val;
  reg [1:0] e_dst;
  reg [4:0] e_flags;
  reg [7:0] e_count;
  reg e_count_we;
  reg [15:0] e_cyc;
  reg e_ok;
  reg [31:0] m;
  reg [31:0] x;
  reg [31:0] r;
  reg [31:0] sign_min;
  reg [5:0] lz;
  reg is_shift;

  always @* begin
    e_val = acc_q;
    e_dst = `DST_ACC;
    e_flags = flags_q;
    e_count = count_q;
    e_count_we = 1'b0;
    e_cyc = `CYC_SHIFT1;
    e_ok = 1'b1;
    m = 32'hffffffff;
    x = 32'h00000000;
    r = 32'h00000000;
    sign_min = 32'h80000000;
    lz = lead_zeros(acc_q);
    is_shift = 1'b0;
    sh_width = `W_LONG;
    sh_mode = `SH_LOGIC_LEFT;
    sh_amount = imm_sel ? imm : count_q;
    case (op)
      `OP_AND_L, `OP_OR_L, `OP_XOR_L: begin
        x = (dst == `DST_MEM) ? mem_q : opnd_q;
        r = (op == `OP_AND_L) ? (acc_q & x) : ((op == `OP_OR_L) ? (acc_q | x) : (acc_q ^ x));
        e_val = r;
        e_flags[`ST_N] = r[31];
        e_flags[`ST_Z] = (r == 32'h00000000);
        e_flags[`ST_V] = 1'b0;
        e_cyc = (dst == `DST_MEM) ? (`CYC_LOGIC_MEM + corr_a + corr_d) : `CYC_LOGIC_REG;
      end
      `OP_NEGATE_BYTE, `OP_NEGATE_WORD: begin
        m = width_mask((op == `OP_NEGATE_BYTE) ? `W_BYTE : `W_WORD);
        sign_min = m & ~(m >> 1);
        x = src & m;
        r = (32'h00000000 - x) & m;
        e_val = (src & ~m) | r;
        e_dst = dst;
        e_flags[`ST_N] = |(r & sign_min);
        e_flags[`ST_Z] = (r == 32'h00000000);
        e_flags[`ST_V] = (x == sign_min);
        e_flags[`ST_C] = (x != 32'h00000000);
        e_cyc = (dst != `DST_MEM) ? `CYC_NEG :
                (`CYC_NEG_MEM + corr_a + ((op == `OP_NEGATE_BYTE) ? corr_b2 : corr_c2));
      end
      `OP_MAGNITUDE_BYTE, `OP_MAGNITUDE_WORD, `OP_MAGNITUDE_LONG: begin
        m = width_mask((op == `OP_MAGNITUDE_BYTE) ? `W_BYTE :
                       ((op == `OP_MAGNITUDE_WORD) ? `W_WORD : `W_LONG));
        sign_min = m & ~(m >> 1);
        x = acc_q & m;
        r = (|(x & sign_min)) ? ((32'h00000000 - x) & m) : x;
        e_val = (acc_q & ~m) | r;
        e_flags[`ST_N] = |(r & sign_min);
        e_flags[`ST_Z] = (r == 32'h00000000);
        e_flags[`ST_V] = (x == sign_min);
        e_cyc = (op == `OP_MAGNITUDE_LONG) ? `CYC_ABS_L : `CYC_ABS_BW;
      end
      `OP_NORMALIZE_LONG: begin
        e_count_we = 1'b1;
        e_flags[`ST_T] = 1'b0;
        if (acc_q == 32'h00000000) begin
          e_count = 8'h00;
          e_cyc = `CYC_NORMALIZE_LONG;
        end else begin
          e_val = acc_q << lz;
          e_count = {2'b00, lz};
          e_cyc = `CYC_NORMALIZE_LONG + {10'h000, lz};
        end
      end
      `OP_ROTATE_RIGHT, `OP_ROTATE_LEFT: begin
        x = src;
        r[7:0] = (op == `OP_ROTATE_RIGHT) ? {flags_q[`ST_C], x[7:1]} : {x[6:0], flags_q[`ST_C]};
        e_val = {x[31:8], r[7:0]};
        e_dst = dst;
        e_flags[`ST_C] = (op == `OP_ROTATE_RIGHT) ? x[0] : x[7];
        e_flags[`ST_N] = r[7];
        e_flags[`ST_Z] = (r[7:0] == 8'h00);
        e_cyc = (dst == `DST_MEM) ? (`CYC_ROT_MEM + corr_a + corr_b2) : `CYC_ROT;
      end
      `OP_ARITH_RIGHT_BYTE, `OP_LOGIC_RIGHT_BYTE, `OP_LOGIC_LEFT_BYTE: begin
        is_shift = 1'b1;
        sh_width = `W_BYTE;
        sh_mode = dir_of(op, `OP_ARITH_RIGHT_BYTE);
        e_cyc = shift_cycles(sh_amount, 1'b0);
      end
      `OP_ARITH_RIGHT_WORD, `OP_LOGIC_RIGHT_WORD, `OP_LOGIC_LEFT_WORD: begin
        is_shift = 1'b1;
        sh_width = `W_WORD;
        sh_mode = dir_of(op, `OP_ARITH_RIGHT_WORD);
        e_cyc = shift_cycles(sh_amount, 1'b0);
      end
      `OP_ARITH_RIGHT_WORD1, `OP_LOGIC_RIGHT_WORD1, `OP_LOGIC_LEFT_WORD1: begin
        is_shift = 1'b1;
        sh_width = `W_WORD;
        sh_mode = dir_of(op, `OP_ARITH_RIGHT_WORD1);
        sh_amount = 8'h01;
        e_cyc = `CYC_SHIFT1;
      end
      `OP_ARITH_RIGHT_LONG, `OP_LOGIC_RIGHT_LONG, `OP_LOGIC_LEFT_LONG: begin
        is_shift = 1'b1;
        sh_width = `W_LONG;
        sh_mode = dir_of(op, `OP_ARITH_RIGHT_LONG);
        e_cyc = shift_cycles(sh_amount, 1'b1);
      end
      default: begin
        e_ok = 1'b0;
      end
    endcase
    if (is_shift) begin
      m = width_mask(sh_width);
      sign_min = m & ~(m >> 1);
      e_val = (acc_q & ~m) | sh_res;
      e_flags[`ST_N] = |(sh_res & sign_min);
      e_flags[`ST_Z] = (sh_res == 32'h00000000);
      // A zero distance moves nothing out, so carry is left alone
      if (sh_amount != 8'h00) begin
        e_flags[`ST_C] = sh_carry;
      end
      e_flags[`ST_T] = (sh_amount != 8'h00) & sh_sticky;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  reg [31:0] rd_data;

  always @* begin
    case (haddr[7:0])
      `OFS_CTRL: rd_data = {16'h0000, ctrl_q};
      `OFS_ACC: rd_data = acc_q;
      `OFS_OPND: rd_data = opnd_q;
      `OFS_MEM: rd_data = mem_q;
      `OFS_COUNT: rd_data = {24'h000000, count_q};
      `OFS_STATUS: rd_data = {last_cyc_q, 7'h00, busy, 3'h0, flags_q};
      `OFS_CORR: rd_data = corr_q;
      default: rd_data = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      busy <= 1'b0;
      state_q <= S_IDLE;
      remain_q <= 16'h0000;
      acc_q <= `RST_WORD;
      opnd_q <= `RST_WORD;
      mem_q <= `RST_WORD;
      count_q <= `RST_BYTE;
      flags_q <= `RST_FLAGS;
      ctrl_q <= 16'h0000;
      corr_q <= `RST_WORD;
      last_cyc_q <= 16'h0000;
      pend_val_q <= `RST_WORD;
      pend_dst_q <= `DST_ACC;
      pend_flags_q <= `RST_FLAGS;
      pend_count_q <= `RST_BYTE;
      pend_count_we_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (clk_en) begin
      ap_wr_q <= ap_valid & hwrite;
      ap_addr_q <= haddr[7:0];
      if (ap_valid & ~hwrite) begin
        hrdata <= rd_data;
      end
      // Operands stay locked while busy so memory updates are atomic
      if (wr_ok) begin
        case (ap_addr_q)
          `OFS_ACC: acc_q <= hwdata;
          `OFS_OPND: opnd_q <= hwdata;
          `OFS_MEM: mem_q <= hwdata;
          `OFS_COUNT: count_q <= hwdata[7:0];
          `OFS_STATUS: flags_q <= hwdata[4:0];
          `OFS_CORR: corr_q <= hwdata;
          default: begin
          end
        endcase
      end
      case (state_q)
        S_IDLE: begin
          if (wr_ok && ap_addr_q == `OFS_CTRL && e_ok) begin
            ctrl_q <= hwdata[15:0];
            pend_val_q <= e_val;
            pend_dst_q <= e_dst;
            pend_flags_q <= e_flags;
            pend_count_q <= e_count;
            pend_count_we_q <= e_count_we;
            last_cyc_q <= e_cyc;
            remain_q <= e_cyc - 16'h0001;
            busy <= 1'b1;
            state_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (remain_q == 16'h0000) begin
            case (pend_dst_q)
              `DST_REG: opnd_q <= pend_val_q;
              `DST_MEM: mem_q <= pend_val_q;
              default: acc_q <= pend_val_q;
            endcase
            flags_q <= pend_flags_q;
            if (pend_count_we_q) begin
              count_q <= pend_count_q;
            end
            busy <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            remain_q <= remain_q - 16'h0001;
          end
        end
        default: begin
          busy <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- hw/shift_unit.v ----
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"

module shift_unit (
  input wire [31:0] val,
  input wire [1:0] width,
  input wire [1:0] mode,
  input wire [7:0] amount,
  output reg [31:0] res,
  output reg carry,
  output reg sticky
);

  reg [31:0] m;
  reg [31:0] x;
  reg [31:0] ext;
  reg [5:0] w;
  reg [63:0] wide;

  always @* begin
    case (width)
      `W_BYTE: begin
        m = 32'h000000ff;
        w = 6'd8;
      end
      `W_WORD: begin
        m = 32'h0000ffff;
        w = 6'd16;
      end
      default: begin
        m = 32'hffffffff;
        w = 6'd32;
      end
    endcase
    x = val & m;
    // Sign copies above the operand width make the right shift arithmetic
    ext = (mode == `SH_ARITH_RIGHT && (|(x & ~(m >> 1)))) ? (x | ~m) : x;
    if (mode == `SH_LOGIC_LEFT) begin
      wide = {32'h00000000, x} << amount;
      res = wide[31:0] & m;
      // The last bit to leave lands just above the operand width
      carry = wide[w];
      sticky = ({2'h0, amount} >= {4'h0, w}) ? (|x) : (|(wide >> w));
    end else begin
      wide = {ext, 32'h00000000};
      if (mode == `SH_ARITH_RIGHT) begin
        wide = $signed(wide) >>> amount;
      end else begin
        wide = wide >> amount;
      end
      res = wide[63:32] & m;
      carry = wide[31];
      sticky = |(x & ~(32'hffffffff << amount));
    end
  end

endmodule

`default_nettype wire

// ---- verification/alu_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"
module alu_checker (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire busy
);
  reg dp_q, cw_q, aw_q;
  reg [4:0] op_q;
  reg [1:0] dst_q;
  reg [7:0] dist_q, count_q;
  reg [31:0] acc_q;
  reg [15:0] len_q;
  // Writes while busy are dropped, so only idle writes are tracked
  wire take = hsel & htrans[1] & hready & clk_en & hwrite & ~busy;
  wire sh_bw = op_q >= `OP_ARITH_RIGHT_BYTE && op_q <= `OP_LOGIC_LEFT_WORD;
  wire sh_l = op_q >= `OP_ARITH_RIGHT_LONG && op_q <= `OP_LOGIC_LEFT_LONG;
  wire [15:0] sh_len = dist_q == 0 ? 16'd3 : (sh_l ? 16'd4 : 16'd3) + {8'h0, dist_q};
  wire [15:0] nr_len = acc_q == 0 ? 16'd5 : 16'd5 + {10'h0, lead0(acc_q)};
  function [5:0] lead0(input [31:0] v);
    integer i;
    begin
      lead0 = 6'd0;
      for (i = 0; i < 32; i = i + 1) if (v[i]) lead0 = 6'd31 - i[5:0];
    end
  endfunction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dp_q, cw_q, aw_q, op_q, dst_q, dist_q, count_q, acc_q, len_q} <= 0;
    end else begin
      dp_q <= take && haddr[7:0] == `OFS_CTRL;
      cw_q <= take && haddr[7:0] == `OFS_COUNT;
      aw_q <= take && haddr[7:0] == `OFS_ACC;
      if (dp_q) begin
        op_q <= hwdata[4:0];
        dst_q <= hwdata[6:5];
        dist_q <= hwdata[7] ? hwdata[15:8] : count_q;
      end
      if (cw_q) count_q <= hwdata[7:0];
      if (aw_q) acc_q <= hwdata;
      len_q <= busy ? len_q + 16'd1 : 16'd0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic_cycles_a: assert property ($rose(busy) && op_q <= `OP_XOR_L && dst_q == `DST_REG
    |-> busy[*5] ##1 !busy) else $error("long logic busy length wrong");
  negate_cycles_a: assert property ($rose(busy) && dst_q != `DST_MEM
    && (op_q == `OP_NEGATE_BYTE || op_q == `OP_NEGATE_WORD) |-> busy[*2] ##1 !busy)
    else $error("negate busy length wrong");
  magnitude_short_a: assert property ($rose(busy)
    && (op_q == `OP_MAGNITUDE_BYTE || op_q == `OP_MAGNITUDE_WORD) |-> busy[*2] ##1 !busy)
    else $error("short magnitude busy length wrong");
  magnitude_long_a: assert property ($rose(busy) && op_q == `OP_MAGNITUDE_LONG
    |-> busy[*4] ##1 !busy) else $error("long magnitude busy length wrong");
  rotate_cycles_a: assert property ($rose(busy) && dst_q != `DST_MEM
    && (op_q == `OP_ROTATE_RIGHT || op_q == `OP_ROTATE_LEFT) |-> busy[*2] ##1 !busy)
    else $error("rotate busy length wrong");
  single_shift_a: assert property ($rose(busy) && op_q >= `OP_ARITH_RIGHT_WORD1
    && op_q <= `OP_LOGIC_LEFT_WORD1 |-> busy[*2] ##1 !busy)
    else $error("single shift busy length wrong");
  shift_length_a: assert property ($fell(busy) && (sh_bw || sh_l)
    |-> len_q == sh_len) else $error("barrel shift busy length wrong");
  normalize_length_a: assert property ($fell(busy) && op_q == `OP_NORMALIZE_LONG
    |-> len_q == nr_len) else $error("normalize busy length wrong");
endmodule
bind logic_shift_normalize_alu alu_checker i_chk (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .busy(busy));
`default_nettype wire

// ---- verification/tb_logic_shift_normalize_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "alu_defines.vh"
module tb_logic_shift_normalize_alu;
  reg hclk = 0;
  reg hresetn = 0;
  reg hsel = 0;
  reg [31:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg hwrite = 0;
  reg clk_en = 1;
  reg [31:0] hwdata = 0;
  wire [31:0] hrdata;
  wire hreadyout, busy, hresp;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  reg [31:0] rd, sts;
  logic_shift_normalize_alu i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .busy(busy));
  initial forever #5 hclk = ~hclk;
  // Longest run is under a thousand cycles; the ceiling leaves ample margin
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    begin
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task check(input [63:0] what, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  // Leaves the final status in sts and the accumulator in rd
  task wait_done;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      rd = 32'h100;
      while (rd[8] !== 1'b0 && n < 500) begin
        xfer(0, `OFS_STATUS, 0);
        n = n + 1;
      end
      // A poll limit that runs out counts as a mismatch
      if (rd[8] !== 1'b0) check("idle", 32'h0, {23'h0, rd[8], 8'h00});
      sts = rd;
      xfer(0, `OFS_ACC, 0);
    end
  endtask
  task one(input [31:0] ctl, input [31:0] ain, input [31:0] sin, input [31:0] aexp,
           input [31:0] fexp, input [31:0] fmask, input [15:0] cexp);
    begin
      xfer(1, `OFS_ACC, ain);
      xfer(1, `OFS_STATUS, sin);
      xfer(1, `OFS_CTRL, ctl);
      wait_done;
      check("acc", aexp, rd);
      check("flags", fexp, sts & fmask);
      check("cycles", {16'h0, cexp}, {16'h0, sts[31:16]});
    end
  endtask
  function [33:0] shref(input [31:0] v, input integer w, input integer m, input integer d);
    reg [31:0] r;
    reg c, t, s;
    integer i;
    begin
      r = v;
      c = 1'b0;
      t = 1'b0;
      for (i = 0; i < d; i = i + 1) begin
        s = r[w-1];
        c = (m == `SH_LOGIC_LEFT) ? s : r[0];
        r = (m == `SH_LOGIC_LEFT) ? r << 1 : r >> 1;
        if (m == `SH_ARITH_RIGHT) r[w-1] = s;
        t = t | c;
      end
      shref = {t, c, r};
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    integer a;
    begin
      for (a = 0; a <= 8'h1c; a = a + 4) begin
        xfer(0, a[7:0], 0);
        check("reset", 32'h0, rd);
        check("hresp", 32'h0, {31'h0, hresp});
      end
    end
  endtask
  task t_logic;
    reg [31:0] e;
    integer i;
    begin
      xfer(1, `OFS_OPND, 32'h8ff0_ff00);
      for (i = 0; i < 3; i = i + 1) begin
        e = i == 0 ? 32'h80f0_1200 : i == 1 ? 32'hfff0_ff34 : 32'h7f00_ed34;
        one(32'h20 | i, 32'hf0f0_1234, 32'h3, e, {e[31], e == 0, 2'b01}, 32'hf, 5);
      end
      xfer(1, `OFS_MEM, 32'h8ff0_ff00);
      xfer(1, `OFS_CORR, 32'h0300_0002);
      one(32'h42, 32'hf0f0_1234, 32'h3, 32'h7f00_ed34, 32'h1, 32'hf, 11);
    end
  endtask
  task t_negate_magnitude;
    begin
      one(`OP_NEGATE_BYTE, 32'h1234_5680, 0, 32'h1234_5680, 32'hb, 32'hf, 2);
      xfer(1, `OFS_MEM, 32'habcd_0001);
      xfer(1, `OFS_CORR, 32'h0004_0002);
      one(32'h44, 32'h5, 0, 32'h5, 32'h9, 32'hf, 13);
      xfer(0, `OFS_MEM, 0);
      check("mem", 32'hffff, {16'h0, rd[15:0]});
      one(`OP_MAGNITUDE_BYTE, 32'haaaa_aa85, 0, 32'haaaa_aa7b, 0, 32'he, 2);
      one(`OP_MAGNITUDE_WORD, 32'h1111_8000, 0, 32'h1111_8000, 32'ha, 32'he, 2);
      one(`OP_MAGNITUDE_LONG, 32'hffff_fffe, 0, 32'h2, 0, 32'he, 4);
    end
  endtask
  task t_normalize_rotate;
    begin
      one(`OP_NORMALIZE_LONG, 32'h0001_0000, 32'h10, 32'h8000_0000, 0, 32'h10, 20);
      xfer(0, `OFS_COUNT, 0);
      check("count", 32'd15, rd);
      one(`OP_NORMALIZE_LONG, 0, 32'h10, 0, 0, 32'h10, 5);
      one(`OP_ROTATE_RIGHT, 32'h5555_5502, 32'h1, 32'h5555_5581, 32'h8, 32'hd, 2);
      xfer(1, `OFS_OPND, 32'h81);
      one(32'h2a, 0, 0, 0, 32'h1, 32'hd, 2);
      xfer(0, `OFS_OPND, 0);
      check("opnd", 32'h2, rd);
      xfer(1, `OFS_MEM, 32'h1);
      xfer(1, `OFS_CORR, 32'h0000_0201);
      one(32'h49, 0, 0, 0, 32'h5, 32'hd, 8);
      xfer(0, `OFS_MEM, 0);
      check("mem", 32'h0, {24'h0, rd[7:0]});
    end
  endtask
  task t_shifts;
    reg [71:0] rdt, idt;
    reg [33:0] f;
    reg [31:0] mk, ctl;
    integer s, k, wi, m, d, w;
    begin
      rdt = {8'd31, 8'd9, 8'd0, 8'd0, 8'd15, 8'd5, 8'd7, 8'd0, 8'd3};
      idt = {8'd1, 8'd0, 8'd31, 8'd8, 8'd0, 8'd15, 8'd7, 8'd1, 8'd0};
      for (s = 0; s < 3; s = s + 1) begin
        for (k = 0; k < 9; k = k + 1) begin
          wi = k / 3;
          m = k % 3;
          w = 8 << wi;
          mk = w == 32 ? 32'hffff_ffff : (32'h1 << w) - 1;
          d = s == 0 ? rdt[k*8 +: 8] : s == 1 ? idt[k*8 +: 8] : 1;
          ctl = (wi == 0 ? 32'h0b : wi == 1 ? 32'h0e : 32'h14) + m;
          if (s == 1) ctl = ctl | 32'h80 | (d << 8);
          if (s == 2) ctl = `OP_ARITH_RIGHT_WORD1 + m;
          xfer(1, `OFS_COUNT, s == 0 ? d : 32'h55);
          f = shref(32'h9a5c_c3a6 & mk, w, m, d);
          f[31:0] = f[31:0] & mk;
          if (s < 2 || wi == 1)
            one(ctl, 32'h9a5c_c3a6, 32'h11, (32'h9a5c_c3a6 & ~mk) | f[31:0],
                {f[33] && d > 0, f[w-1], f[31:0] == 0, 1'b0, d > 0 ? f[32] : 1'b1},
                32'h1d, s == 2 ? 2 : d == 0 ? 3 : (wi == 2 ? 4 : 3) + d);
        end
      end
    end
  endtask
  task t_refused;
    begin
      xfer(1, `OFS_ACC, 32'h1);
      xfer(1, `OFS_COUNT, 32'd31);
      xfer(1, `OFS_CTRL, `OP_LOGIC_LEFT_LONG);
      xfer(1, `OFS_ACC, 32'hdead_beef);
      check("busy", 32'h1, {31'h0, busy});
      wait_done;
      check("acc", 32'h8000_0000, rd);
      xfer(1, `OFS_CTRL, 32'h17);
      xfer(0, `OFS_CTRL, 0);
      check("ctrl", {27'h0, `OP_LOGIC_LEFT_LONG}, rd);
      // A write while the enable is low must be lost
      clk_en <= 1'b0;
      xfer(1, `OFS_ACC, 32'h1234_5678);
      clk_en <= 1'b1;
      xfer(0, `OFS_ACC, 0);
      check("frozen", 32'h8000_0000, rd);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_logic;
    t_negate_magnitude;
    t_normalize_rotate;
    t_shifts;
    t_refused;
    close_out;
  end
endmodule
`default_nettype wire
